// ---- logic/i2css_top.sv ----
/*
 * I2C slave with own-address and control/status registers on Avalon-MM.
 * Assumes a master that holds its request until waitrequest is seen low;
 * the pins are open drain with external pull-ups.
 */
// Contract
// - own address field bits 6:0, read/write, reset zero, compared to A6..A0.
// - control/status writes set controls; reads return status flags instead.
// - bit 31 shows receive DMA active, bit 30 transmit DMA active.
// - bit 4 set after a quick command, cleared by normal transfer or read.
// - bit 5 gives quick command direction, one for read, cleared by read.
// - bit 3 set when second own address matched and own address did not, re-evaluated every compare.
// - writing bit 2 enables or disables the receive FIFO.
// - reading bit 2 shows first data byte arrived; cleared when data read.
// - writing bit 1 enables or disables the transmit FIFO.
// - reading bit 1 shows transmit request with clock held low.
// - writing bit 0 enables slave operation; resets to zero.
// - reading bit 0 shows receive data pending with clock held low.
// - data register carries the byte; ignored while a FIFO is enabled.
`timescale 1ns/100ps
module i2css_top
	import i2css_pkg::*;
(
	input  wire logic          CLK_SYS,
	input  wire logic          RESETN,
	input  wire logic [AW-1:0] AVS_ADDRESS,
	input  wire logic          AVS_READ,
	input  wire logic          AVS_WRITE,
	input  wire logic [31:0]   AVS_WRITEDATA,
	input  wire logic [3:0]    AVS_BYTEENABLE,
	output logic      [31:0]   AVS_READDATA,
	output logic               AVS_WAITREQUEST,
	input  wire logic          RX_DMA_ACTIVE,
	input  wire logic          TX_DMA_ACTIVE,
	input  wire logic          SCL_I,
	output logic               SCL_O,
	output logic               SCL_OE,
	input  wire logic          SDA_I,
	output logic               SDA_O,
	output logic               SDA_OE,
	output logic               IRQ
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		i2css_state_t     state;
		logic [3:0]       cnt;
		logic [7:0]       shreg;
		logic             rw, nack, act, got;
		logic [6:0]       own;
		logic [7:0]       sec;
		logic             en, rxf_en, txf_en;
		logic [7:0]       data;
		logic             rx_req, tx_req, first, fb_pend;
		logic             sec_match, qseen, qdir;
		logic             dma_rx, dma_tx;
		logic [IRQ_W-1:0] ists;
		logic [IRQ_W-1:0] imask;
		logic             scl_oe, sda_oe, irq, wait_q;
		logic [31:0]      rdata;
	} i2css_regs_t;
	i2css_regs_t q;
	i2css_regs_t d;
	logic [1:0] pins;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_p;
	logic       stop_p;
	logic       sda_lvl;

	// ------------------------------------------------------------------
	// pin front end
	// ------------------------------------------------------------------
	i2css_sync #(.W(2)) u_sync (
		.clk(CLK_SYS), .rst_n(RESETN), .din({SCL_I, SDA_I}), .dout(pins)
	);
	i2css_cond u_cond (
		.clk(CLK_SYS), .rst_n(RESETN), .scl(pins[1]), .sda(pins[0]),
		.scl_rise(scl_rise), .scl_fall(scl_fall), .start(start_p), .stop(stop_p),
		.sda_lvl(sda_lvl)
	);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// register read view
	function automatic logic [31:0] rd_value(input i2css_regs_t s, input logic [AW-1:0] a);
		logic fifo;
		fifo     = s.rxf_en | s.txf_en;
		rd_value = 32'h0000_0000;
		case (a)
			OFS_OWN_ADDR:  rd_value = {25'h0, s.own};
			OFS_CTRL_STAT: rd_value = {s.dma_rx, s.dma_tx, 24'h0, s.qdir, s.qseen,
				s.sec_match, s.first, s.tx_req, s.rx_req};
			OFS_DATA:      rd_value = fifo ? 32'h0 : {24'h0, s.data};
			OFS_FIFO_DATA: rd_value = fifo ? {24'h0, s.data} : 32'h0;
			OFS_IRQ_STAT:  rd_value = {28'h0, s.ists};
			OFS_IRQ_MASK:  rd_value = {28'h0, s.imask};
			OFS_SEC_ADDR:  rd_value = {24'h0, s.sec};
			default:       rd_value = 32'h0000_0000;
		endcase
	endfunction

	// access to the byte path currently in use
	function automatic logic data_hit(input i2css_regs_t s, input logic [AW-1:0] a);
		data_hit = (s.rxf_en | s.txf_en) ? (a == OFS_FIFO_DATA) : (a == OFS_DATA);
	endfunction

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic             req, done, wr0, sw_rd, sw_wr, m1, m2;
		logic [IRQ_W-1:0] ev, w1c;
		d     = q;
		req   = AVS_READ | AVS_WRITE;
		done  = req & ~q.wait_q;
		wr0   = done & AVS_WRITE & AVS_BYTEENABLE[0];
		sw_rd = done & AVS_READ & data_hit(q, AVS_ADDRESS);
		sw_wr = wr0 & data_hit(q, AVS_ADDRESS);
		m1    = 1'b0;
		m2    = 1'b0;
		ev    = '0;
		w1c   = '0;

		// bus handshake: one wait cycle, then answer for one cycle
		d.wait_q = ~(req & q.wait_q);
		if (AVS_READ && q.wait_q) begin
			d.rdata = rd_value(q, AVS_ADDRESS);
		end
		d.dma_rx = RX_DMA_ACTIVE;
		d.dma_tx = TX_DMA_ACTIVE;

		// software writes and read side effects
		if (wr0) begin
			unique case (AVS_ADDRESS)
				OFS_OWN_ADDR: d.own = AVS_WRITEDATA[6:0];
				OFS_CTRL_STAT: begin
					d.en     = AVS_WRITEDATA[CS_RX_REQUEST_EN];
					d.txf_en = AVS_WRITEDATA[CS_TREQ_TXF];
					d.rxf_en = AVS_WRITEDATA[CS_FB_RXFIFO];
				end
				OFS_IRQ_STAT: w1c = AVS_WRITEDATA[IRQ_W-1:0];
				OFS_IRQ_MASK: d.imask = AVS_WRITEDATA[IRQ_W-1:0];
				OFS_SEC_ADDR: d.sec = AVS_WRITEDATA[7:0];
				default: ;
			endcase
		end
		if (sw_wr) begin
			d.data = AVS_WRITEDATA[7:0];
		end
		if (done && AVS_READ && AVS_ADDRESS == OFS_CTRL_STAT) begin
			d.qseen = 1'b0;
			d.qdir  = 1'b0;
		end
		if (sw_rd) begin
			d.rx_req = 1'b0;
			d.first  = 1'b0;
		end

		// bus engine
		if (start_p && q.en) begin
			d.state  = ST_ADDR;
			d.cnt    = '0;
			d.act    = 1'b0;
			d.scl_oe = 1'b0;
			d.sda_oe = 1'b0;
		end else if (stop_p) begin
			if (q.act) begin
				ev[IRQ_STOP] = 1'b1;
				if (!q.got) begin
					d.qseen       = 1'b1;
					d.qdir        = q.rw;
					ev[IRQ_QCMD]  = 1'b1;
				end
			end
			d.state  = ST_IDLE;
			d.act    = 1'b0;
			d.scl_oe = 1'b0;
			d.sda_oe = 1'b0;
		end else begin
			unique case (q.state)
				ST_IDLE: ;
				ST_ADDR: begin
					if (scl_rise) begin
						d.shreg = {q.shreg[6:0], sda_lvl};
						d.cnt   = q.cnt + 4'h1;
					end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
						m1 = q.shreg[7:1] == q.own;
						m2 = q.sec[SEC_EN_BIT] && q.shreg[7:1] == q.sec[6:0];
						d.sec_match = m2 & ~m1;
						if (m1 || m2) begin
							d.rw      = q.shreg[0];
							d.act     = 1'b1;
							d.got     = 1'b0;
							d.fb_pend = 1'b1;
							d.sda_oe  = 1'b1;
							d.state   = ST_ADDR_ACK;
						end else begin
							d.state = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						d.sda_oe = 1'b0;
						d.cnt    = '0;
						if (q.rw) begin
							d.scl_oe         = 1'b1;
							d.tx_req         = 1'b1;
							ev[IRQ_TX_REQ]   = 1'b1;
							d.state          = ST_TX_WAIT;
						end else begin
							d.state = ST_RX;
						end
					end
				end
				ST_RX: begin
					if (scl_rise) begin
						d.shreg = {q.shreg[6:0], sda_lvl};
						d.cnt   = q.cnt + 4'h1;
					end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
						d.data         = q.shreg;
						d.rx_req       = 1'b1;
						d.first        = q.fb_pend;
						d.fb_pend      = 1'b0;
						d.got          = 1'b1;
						d.qseen        = 1'b0;
						d.scl_oe       = 1'b1;
						d.sda_oe       = 1'b1;
						ev[IRQ_RX_REQ] = 1'b1;
						d.state        = ST_RX_WAIT;
					end
				end
				ST_RX_WAIT: begin
					if (sw_rd) begin
						d.scl_oe = 1'b0;
						d.state  = ST_RX_ACK;
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						d.sda_oe = 1'b0;
						d.cnt    = '0;
						d.state  = ST_RX;
					end
				end
				ST_TX_WAIT: begin
					if (sw_wr) begin
						d.shreg  = AVS_WRITEDATA[7:0];
						d.sda_oe = ~AVS_WRITEDATA[7];
						d.scl_oe = 1'b0;
						d.tx_req = 1'b0;
						d.cnt    = '0;
						d.state  = ST_TX;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						d.cnt   = q.cnt + 4'h1;
						d.got   = 1'b1;
						d.qseen = 1'b0;
						if (q.cnt == TX_LAST_BIT) begin
							d.sda_oe = 1'b0;
							d.state  = ST_TX_ACK;
						end else begin
							d.shreg  = {q.shreg[6:0], 1'b0};
							d.sda_oe = ~q.shreg[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						d.nack = sda_lvl;
					end else if (scl_fall) begin
						if (!q.nack) begin
							d.scl_oe       = 1'b1;
							d.tx_req       = 1'b1;
							ev[IRQ_TX_REQ] = 1'b1;
							d.state        = ST_TX_WAIT;
						end else begin
							d.act   = 1'b0;
							d.state = ST_IDLE;
						end
					end
				end
				default: d.state = ST_IDLE;
			endcase
		end

		// disabling the slave abandons any transfer at once
		if (!d.en) begin
			d.state  = ST_IDLE;
			d.act    = 1'b0;
			d.rx_req = 1'b0;
			d.first  = 1'b0;
			d.tx_req = 1'b0;
			d.scl_oe = 1'b0;
			d.sda_oe = 1'b0;
		end

		// sticky events: a set in the clearing cycle wins
		d.ists = (q.ists & ~w1c) | ev;
		d.irq  = |(d.ists & d.imask);
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			q        <= '0;
			q.state  <= ST_IDLE;
			q.own    <= OWN_ADDR_RST;
			q.sec    <= SEC_ADDR_RST;
			q.wait_q <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign AVS_READDATA    = q.rdata;
	assign AVS_WAITREQUEST = q.wait_q;
	assign SCL_OE          = q.scl_oe;
	assign SDA_OE          = q.sda_oe;
	assign SCL_O           = 1'b0; // open drain only pulls low
	assign SDA_O           = 1'b0;
	assign IRQ             = q.irq;
endmodule

// ---- logic/i2css_pkg.sv ----
/*
 * Shared constants for the I2C slave control/status block: register
 * offsets, bit positions, reset values, interrupt layout, engine states.
 * Assumes a 12-bit Avalon-MM byte address and 32-bit data.
 */
package i2css_pkg;
	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam int          AW            = 12;
	localparam logic [11:0] OFS_OWN_ADDR  = 12'h800;
	localparam logic [11:0] OFS_CTRL_STAT = 12'h804;
	localparam logic [11:0] OFS_DATA      = 12'h808;
	localparam logic [11:0] OFS_IRQ_STAT  = 12'h820;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h824;
	localparam logic [11:0] OFS_SEC_ADDR  = 12'h828;
	localparam logic [11:0] OFS_FIFO_DATA = 12'h82C;

	// --------------------------------------------------------------
	// control/status bit positions
	// --------------------------------------------------------------
	localparam int CS_RX_DMA    = 31;
	localparam int CS_TX_DMA    = 30;
	localparam int CS_QCMD_DIR  = 5;
	localparam int CS_QCMD_SEEN = 4;
	localparam int CS_SEC_MATCH = 3;
	localparam int CS_FB_RXFIFO = 2;
	localparam int CS_TREQ_TXF  = 1;
	localparam int CS_RX_REQUEST_EN   = 0;
	localparam int SEC_EN_BIT   = 7;

	// --------------------------------------------------------------
	// interrupt status / mask layout
	// --------------------------------------------------------------
	localparam int IRQ_W      = 4;
	localparam int IRQ_RX_REQ = 0;
	localparam int IRQ_TX_REQ = 1;
	localparam int IRQ_STOP   = 2;
	localparam int IRQ_QCMD   = 3;

	// --------------------------------------------------------------
	// reset values and counts
	// --------------------------------------------------------------
	localparam logic [6:0] OWN_ADDR_RST = 7'h00;
	localparam logic [7:0] SEC_ADDR_RST = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] TX_LAST_BIT  = 4'h7;

	// --------------------------------------------------------------
	// bus engine states
	// --------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_ADDR     = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_RX       = 9'h008,
		ST_RX_WAIT  = 9'h010,
		ST_RX_ACK   = 9'h020,
		ST_TX_WAIT  = 9'h040,
		ST_TX       = 9'h080,
		ST_TX_ACK   = 9'h100
	} i2css_state_t;
endpackage

// ---- logic/i2css_sync.sv ----
/*
 * Two-stage synchroniser for the bus pins.
 * Assumes inputs are asynchronous to clk; idle level of the lines is high.
 */
`timescale 1ns/100ps
module i2css_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} i2css_sync_t;

	i2css_sync_t q;
	i2css_sync_t d;

	// first stage feeds only the second
	always_comb begin
		d      = q;
		d.meta = din;
		d.sync = q.meta;
	end

	// idle bus reads high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{meta: '1, sync: '1};
		end else begin
			q <= d;
		end
	end

	assign dout = q.sync;
endmodule

// ---- logic/i2css_cond.sv ----
/*
 * Edge and bus-condition detector: finds SCL edges and START/STOP.
 * Assumes scl and sda already synchronised to clk.
 */
`timescale 1ns/100ps
module i2css_cond (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start,
	output logic      stop,
	output logic      sda_lvl
);
	typedef struct packed {
		logic scl;
		logic sda;
	} i2css_cond_t;

	i2css_cond_t q;
	i2css_cond_t d;

	// remember last sample of each line
	always_comb begin
		d     = q;
		d.scl = scl;
		d.sda = sda;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			q <= d;
		end
	end

	// sda moving while scl high marks start or stop
	assign scl_rise = scl & ~q.scl;
	assign scl_fall = ~scl & q.scl;
	assign start    = scl & q.scl & q.sda & ~sda;
	assign stop     = scl & q.scl & ~q.sda & sda;
	assign sda_lvl  = sda;
endmodule

// ---- testbench/i2css_chk.sv ----
/* port-level assertions for the i2c slave top.
   assumes one clock domain; the bind stands at the foot of this file. */
`timescale 1ns/100ps
module i2css_chk
	import i2css_pkg::*;
(
	input wire logic          CLK_SYS,
	input wire logic          RESETN,
	input wire logic [AW-1:0] AVS_ADDRESS,
	input wire logic          AVS_READ,
	input wire logic          AVS_WRITE,
	input wire logic [31:0]   AVS_WRITEDATA,
	input wire logic [3:0]    AVS_BYTEENABLE,
	input wire logic [31:0]   AVS_READDATA,
	input wire logic          AVS_WAITREQUEST,
	input wire logic          RX_DMA_ACTIVE,
	input wire logic          TX_DMA_ACTIVE,
	input wire logic          SCL_OE,
	input wire logic          SDA_OE
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	// answered status reads, data accesses and dma levels
	wire logic       cs_rd = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CTRL_STAT;
	wire logic       dt_acc = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST
		&& (AVS_ADDRESS == OFS_DATA || AVS_ADDRESS == OFS_FIFO_DATA);
	wire logic [1:0] dma = {RX_DMA_ACTIVE, TX_DMA_ACTIVE};
	property p_wait_one;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("late bus answer");
	property p_rsv;
		cs_rd |-> AVS_READDATA[29:6] == 24'h000000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
	property p_dma;
		cs_rd && $stable(dma) && $past(dma, 2) == dma |-> AVS_READDATA[31:30] == dma;
	endproperty
	a_dma: assert property (p_dma) else $error("dma status wrong");
	property p_qcmd;
		cs_rd && AVS_READDATA[5] |-> AVS_READDATA[4];
	endproperty
	a_qcmd: assert property (p_qcmd) else $error("direction without quick command");
	property p_first;
		cs_rd && AVS_READDATA[2] |-> AVS_READDATA[0];
	endproperty
	a_first: assert property (p_first) else $error("first byte without request");
	property p_stretch;
		cs_rd && (AVS_READDATA[0] || AVS_READDATA[1]) |-> SCL_OE;
	endproperty
	a_stretch: assert property (p_stretch) else $error("request without stretch");
	property p_release;
		dt_acc |-> ##[1:4] !SCL_OE;
	endproperty
	a_release: assert property (p_release) else $error("stretch not released");
	property p_off;
		AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_CTRL_STAT && AVS_BYTEENABLE[0]
			&& !AVS_WRITEDATA[0] |-> ##3 (!SCL_OE && !SDA_OE) [*4];
	endproperty
	a_off: assert property (p_off) else $error("disabled slave drives bus");
endmodule

bind i2css_top i2css_chk u_chk (
	.CLK_SYS(CLK_SYS), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.RX_DMA_ACTIVE(RX_DMA_ACTIVE), .TX_DMA_ACTIVE(TX_DMA_ACTIVE), .SCL_OE(SCL_OE),
	.SDA_OE(SDA_OE)
);

// ---- testbench/i2css_mst_mdl.sv ----
/* i2c master model on open-drain lines, 800 ns bit period.
   assumes the bench resolves both wires with pull-ups. */
`timescale 1ns/100ps
module i2css_mst_mdl (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_lo,
	output logic      sda_lo
);
	// ----
	// bus primitives
	// ----
	// clock stands high outside frames
	initial begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// release scl and wait out any stretching
	task automatic up();
		int n;
		n = 0;
		scl_lo <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (scl !== 1'b1 && n < 3000);
	endtask
	task automatic start();
		sda_lo <= 1'b1;
		w(4);
		scl_lo <= 1'b1;
		w(4);
	endtask
	task automatic stop();
		w(2);
		sda_lo <= 1'b1;
		w(2);
		up();
		w(3);
		sda_lo <= 1'b0;
		w(4);
	endtask
	// nine clocks msb first; a one releases sda, s holds what the wire showed
	task automatic xfer(input logic [8:0] t, output logic [8:0] s);
		for (int j = 8; j >= 0; j--) begin
			w(2);
			sda_lo <= !t[j];
			w(2);
			up();
			s[j] = sda;
			w(3);
			scl_lo <= 1'b1;
		end
	endtask
endmodule

// ---- testbench/i2css_top_tb.sv ----
/* self-checking bench for the i2c slave top.
   assumes the checker is bound and the master model is compiled. */
`timescale 1ns/100ps
module i2css_top_tb
	import i2css_pkg::*;
;
	// ----
	// stimulus and model state
	// ----
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        rd = 1'b0;
	logic        wr_s = 1'b0;
	logic        rxd = 1'b0;
	logic        txd = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wd = 32'h0;
	logic [3:0]  be = 4'hF;
	logic        scl_o, sda_o;
	logic [31:0] rdat, q;
	logic        wreq, scl_oe, sda_oe, irq, m_scl, m_sda;
	wire         scl = !(m_scl || scl_oe);
	wire         sda = !(m_sda || sda_oe);
	logic [31:0] rnd = 32'hADDBCA3B;
	logic [7:0]  sent_q[$];
	logic [6:0]  own;
	logic [8:0]  r;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          i;
	always #50 clk = ~clk;
	i2css_top u_dut (
		.CLK_SYS(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr_s),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .RX_DMA_ACTIVE(rxd), .TX_DMA_ACTIVE(txd), .SCL_I(scl),
		.SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
		.IRQ(irq)
	);
	i2css_mst_mdl m (.clk(clk), .scl(scl), .sda(sda), .scl_lo(m_scl), .sda_lo(m_sda));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// one avalon access; read data lands in q
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		rd <= !w;
		wr_s <= w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 64);
		q = rdat;
		if (n == 64) miscompares++;
		rd <= 1'b0;
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic poll(input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_CTRL_STAT, 32'h0);
			n++;
		end while (q[b] !== 1'b1 && n < 200);
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(OFS_OWN_ADDR, 32'h0);
		rdc(OFS_CTRL_STAT, 32'h0);
		rdc(12'h8F0, 32'h0);
		chk({scl_o, sda_o}, 32'h0);
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			bus(1'b1, OFS_OWN_ADDR, rnd);
			rdc(OFS_OWN_ADDR, rnd & 32'h7F);
			rxd <= i[0];
			txd <= i[1];
			repeat (3) @(posedge clk);
			rdc(OFS_CTRL_STAT, {i[0], i[1], 30'h0});
		end
		own = {1'b1, rnd[5:0]};
		rxd <= 1'b0;
		txd <= 1'b0;
		bus(1'b1, OFS_OWN_ADDR, {25'h0, own});
		// a write without the low byte lane is ignored
		be <= 4'hE;
		bus(1'b1, OFS_OWN_ADDR, 32'h0);
		be <= 4'hF;
		rdc(OFS_OWN_ADDR, {25'h0, own});
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		bus(1'b1, OFS_CTRL_STAT, 32'h1);
		rdc(OFS_CTRL_STAT, 32'h0);
		m.start();
		m.xfer({own ^ 7'h01, 2'b01}, r);
		chk(r[0], 1'b1);
		m.stop();
		// byte from the master, stretched until software reads it
		rnd = lfsr(rnd);
		sent_q.push_back(rnd[7:0]);
		m.start();
		m.xfer({own, 2'b01}, r);
		chk(r[0], 1'b0);
		fork
			m.xfer({rnd[7:0], 1'b1}, r);
			begin
				poll(0);
				rdc(OFS_CTRL_STAT, 32'h5);
				chk(irq, 1'b1);
				rdc(OFS_DATA, sent_q.pop_front());
				rdc(OFS_CTRL_STAT, 32'h0);
				rdc(OFS_IRQ_STAT, 32'h1);
				for (i = 0; i < 3; i++) begin
					bus(1'b1, i < 2 ? OFS_IRQ_MASK : OFS_IRQ_STAT, {31'h0, i != 0});
					@(negedge clk);
					chk(irq, i == 1);
					@(posedge clk);
				end
			end
		join
		chk(r[0], 1'b0);
		m.stop();
		// quick command
		m.start();
		m.xfer({own, 2'b01}, r);
		m.stop();
		rdc(OFS_CTRL_STAT, 32'h10);
		rdc(OFS_CTRL_STAT, 32'h0);
		// quick read: the stretch is released by a byte whose msb leaves sda free
		m.start();
		m.xfer({own, 2'b11}, r);
		chk(r[0], 1'b0);
		fork
			m.stop();
			begin
				poll(1);
				bus(1'b1, OFS_DATA, 32'h80);
			end
		join
		rdc(OFS_CTRL_STAT, 32'h30);
		// byte to the master
		rnd = lfsr(rnd);
		m.start();
		m.xfer({own, 2'b11}, r);
		chk(r[0], 1'b0);
		fork
			m.xfer(9'h1FF, r);
			begin
				poll(1);
				rdc(OFS_CTRL_STAT, 32'h2);
				bus(1'b1, OFS_DATA, {24'h0, rnd[7:0]});
			end
		join
		chk(r[8:1], rnd[7:0]);
		m.stop();
		// second address, then primary
		bus(1'b1, OFS_SEC_ADDR, {24'h0, 1'b1, own ^ 7'h11});
		for (i = 0; i < 2; i++) begin
			m.start();
			m.xfer({i ? own : own ^ 7'h11, 2'b01}, r);
			chk(r[0], 1'b0);
			m.stop();
			rdc(OFS_CTRL_STAT, i ? 32'h10 : 32'h18);
		end
		// fifo path
		bus(1'b1, OFS_CTRL_STAT, 32'h0);
		bus(1'b1, OFS_CTRL_STAT, 32'h7);
		rnd = lfsr(rnd);
		m.start();
		m.xfer({own, 2'b01}, r);
		fork
			m.xfer({rnd[7:0], 1'b1}, r);
			begin
				poll(0);
				rdc(OFS_FIFO_DATA, {24'h0, rnd[7:0]});
			end
		join
		m.stop();
		rdc(OFS_DATA, 32'h0);
		// disabled slave ignores its address
		bus(1'b1, OFS_CTRL_STAT, 32'h0);
		m.start();
		m.xfer({own, 2'b01}, r);
		chk(r[0], 1'b1);
		m.stop();
		give_verdict();
	end
endmodule
